// [hdl/arec_pkg.sv]
// Shared constants and types for the converter rate and excitation control block.
// Assumes an 8-bit special-function-register bus on the single system clock.
package arec_pkg;

  // Register addresses in the special-function-register space
  localparam logic [7:0] ICON_ADDR    = 8'hD5;
  localparam logic [7:0] SF_ADDR      = 8'hD4;

  // Reset values
  localparam logic [7:0] SF_RESET     = 8'h45;
  localparam logic [7:0] ICON_RESET   = 8'h00;

  // Decimation limits; the calibration value is the maximum
  localparam logic [7:0] SF_MIN       = 8'h0D;
  localparam logic [7:0] SF_CAL       = 8'hFF;

  // Update rate is the modulator clock over (3 x 8 x decimation)
  localparam int         MOD_CLK_HZ   = 32768;
  localparam logic [4:0] DECIM_MULT   = 5'h18;
  localparam int         CNT_W        = 13;

  // Conversion periods before the first valid result (chopped inputs)
  localparam logic [1:0] SETTLE_PERIODS = 2'h2;

  // Field positions of the current-source control register
  localparam int ICON_RSVD_BIT   = 7;
  localparam int ICON_BURNOUT    = 6;
  localparam int ICON_AUX_CORR   = 5;
  localparam int ICON_PRI_CORR   = 4;
  localparam int ICON_SRC2_PIN   = 3;
  localparam int ICON_SRC1_PIN   = 2;
  localparam int ICON_SRC2_EN    = 1;
  localparam int ICON_SRC1_EN    = 0;

  // Stored current-source fields, bit 6 down to bit 0
  typedef struct packed {
    logic burnout_enable;
    logic aux_current_correction;
    logic primary_current_correction;
    logic source_two_pin_select;
    logic source_one_pin_select;
    logic source_two_enable;
    logic source_one_enable;
  } arec_icon_t;

  // One register-bus request
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } arec_sfr_req_t;

  // Settling progress after a conversion starts
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SETTLE1 = 2'b01,
    ST_SETTLE2 = 2'b10,
    ST_RUN     = 2'b11
  } arec_settle_t;

endpackage : arec_pkg

// [hdl/arec_rate_div.sv]
// Conversion period generator: counts modulator ticks up to 24 x decimation.
// Assumes the modulator tick is a one-cycle pulse on the system clock.
`timescale 1ns/10ps
module arec_rate_div (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       mod_tick,
  input  wire logic [7:0] decim,
  output logic            period_tick
);

  logic [arec_pkg::CNT_W-1:0] count_reg;
  logic [arec_pkg::CNT_W-1:0] last_cnt;

  // Period length in modulator ticks, less one
  function automatic logic [arec_pkg::CNT_W-1:0] period_last(input logic [7:0] d);
    logic [arec_pkg::CNT_W-1:0] p;
    p = arec_pkg::CNT_W'(d) * arec_pkg::CNT_W'(arec_pkg::DECIM_MULT);
    return p - arec_pkg::CNT_W'(1);
  endfunction : period_last

  assign last_cnt = period_last(decim);

  // Count ticks; restart from zero whenever no conversion runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (!run) begin
      count_reg <= '0;
    end else if (mod_tick) begin
      // >= guards against a shorter period chosen in mid-count
      if (count_reg >= last_cnt) count_reg <= '0;
      else count_reg <= count_reg + arec_pkg::CNT_W'(1);
    end
  end

  // One pulse at the end of each conversion period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) period_tick <= 1'b0;
    else period_tick <= run && mod_tick && (count_reg >= last_cnt);
  end

endmodule : arec_rate_div

// [hdl/arec_ctrl.sv]
// Decimation-ratio and current-source control registers for two converters.
// Assumes converter status and modulator tick come from logic on CLOCK.
// What this block does
// - Update rate is modulator clock over twenty-four times decimation value.
// - Decimation register writes are blocked while either converter is active.
// - One decimation setting paces primary and auxiliary results alike.
// - Reset loads decimation register with 45H.
// - First valid result comes only after two conversion periods from idle; a converter joining a run does not wait.
// - Calibration always runs with decimation FFH.
// - After calibration the programmed decimation is visible and used again.
// - Reset clears current-source register to 00H.
// - Bit 6 switches both burnout currents on or off.
// - Bit 5 enables auxiliary result current correction.
// - Bit 4 enables primary result current correction.
// - Bit 3 set routes source two to first pin, clear to second.
// - Bit 2 set routes source one to second pin, clear to first.
// - Bit 1 turns source two on or off.
// - Bit 0 turns source one on or off.
// - Both sources may share one pin for combined current.
`timescale 1ns/10ps
module arec_ctrl (
  input  wire logic       CLOCK,
  input  wire logic       RSTN,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  input  wire logic [7:0] SFR_WDATA,
  input  wire logic       PRIMARY_ACTIVE,
  input  wire logic       AUX_ACTIVE,
  input  wire logic       CAL_ACTIVE,
  input  wire logic       MOD_TICK,
  output logic      [7:0] SFR_RDATA,
  output logic      [7:0] DECIM_RATIO,
  output logic            PRI_RESULT_STROBE,
  output logic            AUX_RESULT_STROBE,
  output logic            BURNOUT_EN,
  output logic            PRI_CORR_EN,
  output logic            AUX_CORR_EN,
  output logic            FIRST_PIN_SRC1,
  output logic            FIRST_PIN_SRC2,
  output logic            SECOND_PIN_SRC1,
  output logic            SECOND_PIN_SRC2
);

  logic                  rst_meta_reg;
  logic                  rst_n;
  arec_pkg::arec_sfr_req_t req;
  logic [7:0]            sf_reg;
  arec_pkg::arec_icon_t  icon_reg;
  logic [7:0]            decim_eff;
  logic                  conv_busy;
  logic                  run;
  logic                  period_tick;
  arec_pkg::arec_settle_t settle_reg;
  arec_pkg::arec_settle_t settle_next;
  logic                  result_ok;

  // Source reaches a pin when enabled and routed there
  function automatic logic drives_pin(input logic en, input logic routed);
    return en & routed;
  endfunction : drives_pin

  // Reset release passes two flops so all flops leave reset on one edge
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Bundle the bus request
  assign req = '{addr: SFR_ADDR, wr: SFR_WR, rd: SFR_RD, wdata: SFR_WDATA};

  // Converter status is same-clock logic, so no synchroniser here
  assign conv_busy = PRIMARY_ACTIVE | AUX_ACTIVE | CAL_ACTIVE;
  assign run       = conv_busy;

  // Calibration overrides the programmed ratio without touching it
  assign decim_eff = CAL_ACTIVE ? arec_pkg::SF_CAL : sf_reg;

  // Decimation register; the store is kept while a converter runs
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      sf_reg <= arec_pkg::SF_RESET;
    end else if (req.wr && req.addr == arec_pkg::SF_ADDR && !conv_busy) begin
      // Values below 0DH are software's fault and are stored as written
      sf_reg <= req.wdata;
    end
  end

  // Current-source register; whole-byte writes only, bit 7 not stored
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      icon_reg <= arec_pkg::arec_icon_t'(arec_pkg::ICON_RESET[6:0]);
    end else if (req.wr && req.addr == arec_pkg::ICON_ADDR) begin
      icon_reg <= arec_pkg::arec_icon_t'(req.wdata[6:0]);
    end
  end

  // Read data register; unmapped addresses answer zero
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      SFR_RDATA <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        arec_pkg::SF_ADDR:   SFR_RDATA <= decim_eff;
        arec_pkg::ICON_ADDR: SFR_RDATA <= {1'b0, icon_reg};
        default:             SFR_RDATA <= 8'h00;
      endcase
    end
  end

  // One period generator serves both converters
  arec_rate_div u_rate_div (
    .clk         (CLOCK),
    .rst_n       (rst_n),
    .run         (run),
    .mod_tick    (MOD_TICK),
    .decim       (decim_eff),
    .period_tick (period_tick)
  );

  // Settling walk: chopping needs two periods before the first result
  always_comb begin
    settle_next = settle_reg;
    unique case (settle_reg)
      arec_pkg::ST_IDLE:    if (run) settle_next = arec_pkg::ST_SETTLE1;
      arec_pkg::ST_SETTLE1: if (period_tick) settle_next = arec_pkg::ST_SETTLE2;
      arec_pkg::ST_SETTLE2: if (period_tick) settle_next = arec_pkg::ST_RUN;
      arec_pkg::ST_RUN:     settle_next = arec_pkg::ST_RUN;
    endcase
    if (!run) settle_next = arec_pkg::ST_IDLE;
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) settle_reg <= arec_pkg::ST_IDLE;
    else settle_reg <= settle_next;
  end

  // A period end is a result only at the end of the second period or later
  assign result_ok = period_tick && !CAL_ACTIVE &&
                     (settle_reg == arec_pkg::ST_SETTLE2 || settle_reg == arec_pkg::ST_RUN);

  // Both result strobes come from the same tick, so rates match
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      PRI_RESULT_STROBE <= 1'b0;
      AUX_RESULT_STROBE <= 1'b0;
    end else begin
      PRI_RESULT_STROBE <= result_ok && PRIMARY_ACTIVE;
      AUX_RESULT_STROBE <= result_ok && AUX_ACTIVE;
    end
  end

  // Ratio in use, for the filter
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) DECIM_RATIO <= arec_pkg::SF_RESET;
    else DECIM_RATIO <= decim_eff;
  end

  // Burnout and correction controls
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      BURNOUT_EN  <= 1'b0;
      PRI_CORR_EN <= 1'b0;
      AUX_CORR_EN <= 1'b0;
    end else begin
      BURNOUT_EN  <= icon_reg.burnout_enable;
      AUX_CORR_EN <= icon_reg.aux_current_correction;
      PRI_CORR_EN <= icon_reg.primary_current_correction;
    end
  end

  // Excitation routing; sharing a pin is allowed, nothing blocks it
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      FIRST_PIN_SRC1  <= 1'b0;
      FIRST_PIN_SRC2  <= 1'b0;
      SECOND_PIN_SRC1 <= 1'b0;
      SECOND_PIN_SRC2 <= 1'b0;
    end else begin
      FIRST_PIN_SRC2  <= drives_pin(icon_reg.source_two_enable,
                                    icon_reg.source_two_pin_select);
      SECOND_PIN_SRC2 <= drives_pin(icon_reg.source_two_enable,
                                    !icon_reg.source_two_pin_select);
      SECOND_PIN_SRC1 <= drives_pin(icon_reg.source_one_enable,
                                    icon_reg.source_one_pin_select);
      FIRST_PIN_SRC1  <= drives_pin(icon_reg.source_one_enable,
                                    !icon_reg.source_one_pin_select);
    end
  end

  // Checks on the register and settling behaviour
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n);

  sequence s_sf_write_busy;
    req.wr && req.addr == arec_pkg::SF_ADDR && conv_busy;
  endsequence

  sequence s_sf_write_free;
    req.wr && req.addr == arec_pkg::SF_ADDR && !conv_busy;
  endsequence

  AST_SF_LOCKED: assert property (s_sf_write_busy |=> $stable(sf_reg))
    else $error("Decimation register changed while a converter ran");

  AST_SF_WRITE_TAKEN: assert property (s_sf_write_free |=> sf_reg == $past(req.wdata))
    else $error("Decimation write not stored while idle");

  AST_CAL_MAX: assert property (CAL_ACTIVE |=> DECIM_RATIO == arec_pkg::SF_CAL)
    else $error("Calibration did not use maximum decimation");

  AST_CAL_RESTORE: assert property ($fell(CAL_ACTIVE) |=> DECIM_RATIO == sf_reg)
    else $error("Programmed decimation not restored after calibration");

  AST_ICON_RSVD: assert property (req.rd && req.addr == arec_pkg::ICON_ADDR
                                  |=> SFR_RDATA[7] == 1'b0)
    else $error("Reserved current-source bit read as one");

  AST_FIRST_RESULT: assert property ($rose(PRIMARY_ACTIVE) && !AUX_ACTIVE && !CAL_ACTIVE
                                     |=> !PRI_RESULT_STROBE [*8])
    else $error("Result strobe too soon after conversion start");

  AST_NO_EARLY: assert property (PRI_RESULT_STROBE || AUX_RESULT_STROBE
                                 |-> $past(settle_reg) inside {arec_pkg::ST_SETTLE2,
                                                               arec_pkg::ST_RUN})
    else $error("Result strobe before two periods had passed");

  AST_SAME_RATE: assert property (PRIMARY_ACTIVE && AUX_ACTIVE && $past(PRIMARY_ACTIVE)
                                  && $past(AUX_ACTIVE)
                                  |-> PRI_RESULT_STROBE == AUX_RESULT_STROBE)
    else $error("Primary and auxiliary results out of step");

  AST_BURNOUT: assert property (req.wr && req.addr == arec_pkg::ICON_ADDR
                                |=> ##1 BURNOUT_EN == $past(req.wdata[6], 2))
    else $error("Burnout enable does not follow its bit");

  AST_SRC2_ROUTE: assert property (icon_reg.source_two_enable && icon_reg.source_two_pin_select
                                   |=> FIRST_PIN_SRC2 && !SECOND_PIN_SRC2)
    else $error("Source two not routed to first pin");

  AST_SHARED_PIN: assert property (icon_reg.source_one_enable && !icon_reg.source_one_pin_select
                                   && icon_reg.source_two_enable
                                   && icon_reg.source_two_pin_select
                                   |=> FIRST_PIN_SRC1 && FIRST_PIN_SRC2)
    else $error("Shared pin combination was blocked");

endmodule : arec_ctrl

// [dv/arec_ctrl_tb.sv]
// Self-checking bench for the converter rate and excitation control block.
// Assumes the register bus and converter status are driven here on CLOCK.
`timescale 1ns/10ps
module arec_ctrl_tb;
  logic        CLOCK, RSTN, SFR_WR, SFR_RD, PRIMARY_ACTIVE, AUX_ACTIVE, CAL_ACTIVE, MOD_TICK;
  logic  [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, DECIM_RATIO;
  logic        PRI_RESULT_STROBE, AUX_RESULT_STROBE, BURNOUT_EN, PRI_CORR_EN, AUX_CORR_EN;
  logic        FIRST_PIN_SRC1, FIRST_PIN_SRC2, SECOND_PIN_SRC1, SECOND_PIN_SRC2;
  logic  [7:0] exp_q[$];
  logic  [7:0] exp_rd;
  logic  [7:0] v;
  logic  [7:0] tbl[4] = '{8'h43, 8'h0B, 8'h07, 8'hFF};
  logic  [7:0] dtbl[2] = '{8'h0D, 8'h10};
  logic        rd_d1, rd_d2;
  int          n_fail, cmp_count, cyc, n, seed_val, strobes;

  arec_ctrl arec_ctrl_inst (.CLOCK(CLOCK), .RSTN(RSTN), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
    .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .PRIMARY_ACTIVE(PRIMARY_ACTIVE),
    .AUX_ACTIVE(AUX_ACTIVE), .CAL_ACTIVE(CAL_ACTIVE), .MOD_TICK(MOD_TICK),
    .SFR_RDATA(SFR_RDATA), .DECIM_RATIO(DECIM_RATIO), .PRI_RESULT_STROBE(PRI_RESULT_STROBE),
    .AUX_RESULT_STROBE(AUX_RESULT_STROBE), .BURNOUT_EN(BURNOUT_EN), .PRI_CORR_EN(PRI_CORR_EN),
    .AUX_CORR_EN(AUX_CORR_EN), .FIRST_PIN_SRC1(FIRST_PIN_SRC1),
    .FIRST_PIN_SRC2(FIRST_PIN_SRC2), .SECOND_PIN_SRC1(SECOND_PIN_SRC1),
    .SECOND_PIN_SRC2(SECOND_PIN_SRC2));

  // 125 MHz system clock
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end

  // Closing report, the single place the run ends
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask : chk

  // Write strobe held for exactly one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    SFR_ADDR  = a;
    SFR_WDATA = d;
    SFR_WR    = 1'b1;
    @(negedge CLOCK);
    SFR_WR = 1'b0;
    @(negedge CLOCK);
  endtask : wr

  // Reads are spaced so the answer is sampled before the next read is taken
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    SFR_ADDR = a;
    SFR_RD   = 1'b1;
    @(negedge CLOCK);
    SFR_RD = 1'b0;
    @(negedge CLOCK);
    @(negedge CLOCK);
  endtask : rd

  // Current-source outputs as seen by the pins, gated by each enable
  function automatic logic [6:0] icon_exp(input logic [7:0] x);
    return {x[6], x[5], x[4], x[0] & ~x[2], x[1] & x[3], x[0] & x[2], x[1] & ~x[3]};
  endfunction : icon_exp

  task automatic wait_strobe(output int cnt);
    cnt = 0;
    do begin
      @(negedge CLOCK);
      cnt++;
    end while (PRI_RESULT_STROBE !== 1'b1 && cnt < 1000);
  endtask : wait_strobe

  // Read answer monitor: oldest note is compared when the answer is due
  always @(posedge CLOCK) begin
    rd_d1 <= SFR_RD;
    rd_d2 <= rd_d1;
  end
  always @(negedge CLOCK) begin
    if (rd_d2 === 1'b1 && exp_q.size() > 0) begin
      exp_rd = exp_q.pop_front();
      chk(SFR_RDATA, exp_rd, "read data");
    end
  end

  // Hang guard: the full sequence needs well under 8000 cycles
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("MISMATCH at %0t: timeout", $time);
      end_of_test();
    end
  end

  initial begin
    {RSTN, SFR_WR, SFR_RD, PRIMARY_ACTIVE, AUX_ACTIVE, CAL_ACTIVE, MOD_TICK} = 7'h00;
    SFR_ADDR  = 8'h00;
    SFR_WDATA = 8'h00;
    rd_d1 = 1'b0;
    rd_d2 = 1'b0;
    seed_val = $urandom(32'hf580c357);
    repeat (16) @(negedge CLOCK);
    RSTN = 1'b1;
    repeat (3) @(negedge CLOCK);
    // Reset state of both registers and all pins
    chk(DECIM_RATIO, 8'h45, "decim reset");
    chk({BURNOUT_EN, AUX_CORR_EN, PRI_CORR_EN, FIRST_PIN_SRC1, FIRST_PIN_SRC2,
         SECOND_PIN_SRC1, SECOND_PIN_SRC2}, 7'h00, "icon reset");
    rd(8'hD4, 8'h45);
    rd(8'hD5, 8'h00);
    rd(8'h00, 8'h00);
    // Current-source fields: four fixed words, two of them shared pin cases, then random words
    for (int i = 0; i < 10; i++) begin
      v = (i < 4) ? tbl[i] : 8'($urandom);
      wr(8'hD5, v);
      @(negedge CLOCK);
      chk({BURNOUT_EN, AUX_CORR_EN, PRI_CORR_EN, FIRST_PIN_SRC1, FIRST_PIN_SRC2,
           SECOND_PIN_SRC1, SECOND_PIN_SRC2}, icon_exp(v), "icon pins");
      rd(8'hD5, v & 8'h7F);
    end
    // Decimation writes while idle take effect; while any converter runs they drop
    wr(8'hD4, 8'h0D);
    rd(8'hD4, 8'h0D);
    chk(DECIM_RATIO, 8'h0D, "decim in use");
    for (int k = 0; k < 3; k++) begin
      {CAL_ACTIVE, AUX_ACTIVE, PRIMARY_ACTIVE} = 3'(1 << k);
      @(negedge CLOCK);
      wr(8'hD4, 8'h80);
      {CAL_ACTIVE, AUX_ACTIVE, PRIMARY_ACTIVE} = 3'h0;
      repeat (2) @(negedge CLOCK);
      rd(8'hD4, 8'h0D);
    end
    // Calibration forces the maximum and produces no results
    MOD_TICK   = 1'b1;
    CAL_ACTIVE = 1'b1;
    repeat (2) @(negedge CLOCK);
    chk(DECIM_RATIO, 8'hFF, "decim in cal");
    rd(8'hD4, 8'hFF);
    strobes = 0;
    repeat (700) begin
      @(negedge CLOCK);
      if (PRI_RESULT_STROBE === 1'b1 || AUX_RESULT_STROBE === 1'b1) strobes++;
    end
    chk(strobes, 0, "strobe in cal");
    CAL_ACTIVE = 1'b0;
    repeat (2) @(negedge CLOCK);
    chk(DECIM_RATIO, 8'h0D, "decim after cal");
    rd(8'hD4, 8'h0D);
    // Pacing: tick every cycle, so one period is 24 x decimation cycles
    for (int j = 0; j < 2; j++) begin
      {PRIMARY_ACTIVE, AUX_ACTIVE} = 2'b00;
      repeat (2) @(negedge CLOCK);
      wr(8'hD4, dtbl[j]);
      PRIMARY_ACTIVE = 1'b1;
      AUX_ACTIVE     = 1'b1;
      wait_strobe(n);
      chk(AUX_RESULT_STROBE, 1'b1, "aux with pri");
      chk(n >= 48 * dtbl[j] - 4 && n <= 48 * dtbl[j] + 6, 1, "first result late/early");
      wait_strobe(n);
      chk(n, 24 * dtbl[j], "period length");
      chk(AUX_RESULT_STROBE, 1'b1, "aux same rate");
    end
    {PRIMARY_ACTIVE, AUX_ACTIVE, MOD_TICK} = 3'h0;
    repeat (4) @(negedge CLOCK);
    end_of_test();
  end
endmodule : arec_ctrl_tb
